// *** dsr_lowpower.sv ***
// dsr_lowpower: self-refresh and power-down state control of the memory
// assumes: controller keeps its own entry/exit duties; CK runs when sampled
// Behaviour
// R1: self-refresh entry is CS, RAS, CAS, CKE low with WE high.
// R2: controller enters self-refresh only with device idle, banks precharged.
// R3: controller turns ODT off before self-refresh entry.
// R4: controller keeps CKE low to stay in self-refresh.
// R5: DLL off on self-refresh entry, back on with DLL reset at exit.
// R6: after floating reference, no write for 512 clocks after exit.
// R7: device starts an internal refresh within tCKE of self-refresh entry.
// R8: controller stays in self-refresh at least the minimum residency.
// R9: controller stops clock only after hold time, restarts before exit.
// R10: exit is CKE high with NOP; then wait tXS or DLL lock.
// R11: controller holds CKE high and ODT off during DLL-lock period.
// R12: before re-entry wait tXS and issue one extra refresh.
// R13: only NOP or deselect during tXS after exit.
// R14: power-down entered on CKE low with NOP or deselect.
// R15: controller never lowers CKE during mode, ZQ, DLL lock, read, write.
// R16: precharge power-down if all banks closed, else active power-down.
// R17: after power-down entered unlocked, controller resets the DLL.
// R18: buffers off in power-down; command receivers off after entry delay.
// R19: A12 clear: precharge power-down turns DLL off, slow exit.
// R20: reset low during power-down forces the reset state.
// R21: controller holds CKE low tCKE, clock stable, stay under 9 tREFI.
// R22: power-down exits on CKE high with NOP; then tXP or tXPDLL wait.
`timescale 1ns/100ps
`default_nettype none
module dsr_lowpower #(
  parameter int TXSDLL = dsr_pkg::TXSDLL_NCK
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic CKE,
  input wire dsr_pkg::dsr_cmd_t CMD,
  input wire logic ANY_BANK_OPEN,
  input wire logic MR1_A0,
  input wire logic MR0_A12,
  output var dsr_pkg::dsr_status_t STATUS,
  output logic CMD_READY,
  output logic DLL_READY
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic cke_q;
  logic is_nop;
  logic sr_entry;
  logic pd_entry;
  logic lp_exit;

  // deselect or nop both count as no-operation
  assign is_nop = CMD.cs_n ||
                  (CMD.ras_n && CMD.cas_n && CMD.we_n);
  assign sr_entry = cke_q && !CKE && !CMD.cs_n && !CMD.ras_n &&
                    !CMD.cas_n && CMD.we_n;                  // [R1]
  assign pd_entry = cke_q && !CKE && is_nop;                 // [R14]
  assign lp_exit = !cke_q && CKE && is_nop;                  // [R10] [R22]

  ////////////////////////////////////////////////////////////////////////////
  // state

  dsr_pkg::dsr_state_t state_q;
  dsr_pkg::dsr_state_t state_d;
  logic dll_lock_q;
  logic dll_lock_d;
  logic [dsr_pkg::CNT_W-1:0] dll_cnt_q;
  logic [dsr_pkg::CNT_W-1:0] dll_cnt_d;
  logic [dsr_pkg::CNT_W-1:0] rx_cnt_q;
  logic [dsr_pkg::CNT_W-1:0] rx_cnt_d;
  logic dll_enabled;
  logic in_lp;
  logic pd_state;
  logic tmr_load;
  logic [dsr_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;
  logic ref_load;
  logic ref_done;
  logic ref_pend_q;
  logic ref_pend_d;
  logic dll_restart;

  assign dll_enabled = (MR1_A0 == 1'b0);
  assign pd_state = (state_q == dsr_pkg::ST_PD_ACTIVE) ||
                    (state_q == dsr_pkg::ST_PD_PRE_FAST) ||
                    (state_q == dsr_pkg::ST_PD_PRE_SLOW);
  assign in_lp = pd_state || (state_q == dsr_pkg::ST_SELF_REFRESH);

  always_comb begin
    state_d = state_q;
    case (state_q)
      dsr_pkg::ST_IDLE: begin
        if (sr_entry) state_d = dsr_pkg::ST_SELF_REFRESH;
        else if (pd_entry) begin
          if (ANY_BANK_OPEN) state_d = dsr_pkg::ST_PD_ACTIVE;   // [R16]
          else if (MR0_A12) state_d = dsr_pkg::ST_PD_PRE_FAST; // [R19]
          else state_d = dsr_pkg::ST_PD_PRE_SLOW;              // [R19]
        end
      end
      dsr_pkg::ST_SELF_REFRESH: begin
        if (lp_exit) state_d = dsr_pkg::ST_SR_EXIT;
      end
      dsr_pkg::ST_SR_EXIT: begin
        if (sr_entry) state_d = dsr_pkg::ST_SELF_REFRESH;
        else if (tmr_done) state_d = dsr_pkg::ST_IDLE;
      end
      dsr_pkg::ST_PD_ACTIVE, dsr_pkg::ST_PD_PRE_FAST: begin
        if (lp_exit) state_d = dsr_pkg::ST_PD_EXIT;
      end
      dsr_pkg::ST_PD_PRE_SLOW: begin
        if (lp_exit) state_d = dsr_pkg::ST_PD_EXIT;
        // banks may still close after entry from an auto-precharge
      end
      dsr_pkg::ST_PD_EXIT: begin
        if (tmr_done) state_d = dsr_pkg::ST_IDLE;
      end
      default: state_d = dsr_pkg::ST_IDLE;
    endcase
    // reset pin wins over any low-power state
    if (!RESET_N) state_d = dsr_pkg::ST_IDLE;                // [R20]
  end

  // exit waits: tXS after self-refresh, tXP after power-down
  assign tmr_load = lp_exit && in_lp;
  assign tmr_val = (state_q == dsr_pkg::ST_SELF_REFRESH) ?
                   dsr_pkg::CNT_W'(dsr_pkg::TXS_CYC) :        // [R10]
                   dsr_pkg::CNT_W'(dsr_pkg::TXP_CYC);         // [R22]

  // internal refresh timer started on self-refresh entry
  assign ref_load = sr_entry;
  assign ref_pend_d = ref_load ? 1'b1 :
                      (ref_pend_q && ref_done) ? 1'b0 : ref_pend_q;

  // dll relocks after self-refresh exit or after slow power-down exit
  assign dll_restart = lp_exit &&
                       ((state_q == dsr_pkg::ST_SELF_REFRESH) ||
                        (state_q == dsr_pkg::ST_PD_PRE_SLOW));
  assign dll_cnt_d = dll_restart ?
                     ((state_q == dsr_pkg::ST_SELF_REFRESH) ?
                      dsr_pkg::CNT_W'(TXSDLL) :               // [R5]
                      dsr_pkg::CNT_W'(dsr_pkg::TXPDLL_CYC)) : // [R19]
                     (dll_cnt_q != '0) ? dll_cnt_q - dsr_pkg::CNT_W'(1) :
                     dll_cnt_q;
  assign dll_lock_d = !dll_enabled ? 1'b0 :
                      (sr_entry || (pd_entry && !ANY_BANK_OPEN &&
                       !MR0_A12)) ? 1'b0 :                    // [R5] [R19]
                      dll_restart ? 1'b0 :
                      (!in_lp && dll_cnt_q == '0) ? 1'b1 : dll_lock_q;

  // command receivers stay on for the entry delay
  assign rx_cnt_d = (sr_entry || pd_entry) ?
                    dsr_pkg::CNT_W'(dsr_pkg::TCPDED_NCK) :    // [R18]
                    (rx_cnt_q != '0) ? rx_cnt_q - dsr_pkg::CNT_W'(1) :
                    rx_cnt_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= dsr_pkg::ST_IDLE;
      cke_q <= 1'b0;
      dll_lock_q <= 1'b0;
      dll_cnt_q <= '0;
      rx_cnt_q <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_q <= CKE;
      dll_lock_q <= dll_lock_d;
      dll_cnt_q <= dll_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      ref_pend_q <= ref_pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers

  dsr_timer #(.W(dsr_pkg::CNT_W)) u_exit_tmr (
    .clk(CLK),
    .rst(RST),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  dsr_timer #(.W(dsr_pkg::CNT_W)) u_ref_tmr (
    .clk(CLK),
    .rst(RST),
    .load(ref_load),
    .value(dsr_pkg::CNT_W'(dsr_pkg::TCKE_CYC)),
    .done(ref_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  dsr_pkg::dsr_status_t status_d;

  always_comb begin
    status_d.in_self_refresh = (state_d == dsr_pkg::ST_SELF_REFRESH);
    status_d.in_power_down = (state_d == dsr_pkg::ST_PD_ACTIVE) ||
                             (state_d == dsr_pkg::ST_PD_PRE_FAST) ||
                             (state_d == dsr_pkg::ST_PD_PRE_SLOW);
    status_d.pd_active = (state_d == dsr_pkg::ST_PD_ACTIVE);   // [R16]
    status_d.pd_slow_exit = (state_d == dsr_pkg::ST_PD_PRE_SLOW);
    status_d.dll_on = dll_enabled &&
                      (state_d != dsr_pkg::ST_SELF_REFRESH) &&
                      (state_d != dsr_pkg::ST_PD_PRE_SLOW);   // [R5] [R19]
    status_d.dll_reset = dll_restart &&
                         (state_q == dsr_pkg::ST_SELF_REFRESH) &&
                         dll_enabled;                          // [R5]
    // buffers off in low power, receivers linger for the entry delay
    status_d.io_buf_on = !(status_d.in_power_down ||
                           status_d.in_self_refresh);          // [R18]
    status_d.cmd_rx_on = status_d.io_buf_on ||
                         (rx_cnt_d != '0);                     // [R18]
    status_d.refresh_req = ref_pend_q && ref_done &&
                           (state_q == dsr_pkg::ST_SELF_REFRESH); // [R7]
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      STATUS <= '0;
      CMD_READY <= 1'b0;
      DLL_READY <= 1'b0;
    end else begin
      STATUS <= status_d;
      CMD_READY <= (state_d == dsr_pkg::ST_IDLE);             // [R10] [R22]
      DLL_READY <= dll_lock_d && (state_d == dsr_pkg::ST_IDLE);
    end
  end

endmodule : dsr_lowpower
`default_nettype wire

// *** dsr_pkg.sv ***
// dsr_pkg: commands, states and timing constants for the low-power control
// assumes: one clock domain, command pins sampled on the rising clock edge
package dsr_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dsr_cmd_t;

  typedef enum {
    ST_IDLE,
    ST_SELF_REFRESH,
    ST_SR_EXIT,
    ST_PD_ACTIVE,
    ST_PD_PRE_FAST,
    ST_PD_PRE_SLOW,
    ST_PD_EXIT
  } dsr_state_t;

  typedef struct packed {
    logic in_self_refresh;
    logic in_power_down;
    logic pd_active;
    logic pd_slow_exit;
    logic dll_on;
    logic dll_reset;
    logic cmd_rx_on;
    logic io_buf_on;
    logic refresh_req;
  } dsr_status_t;

  localparam int CLK_MHZ = 250;
  // delay from self-refresh entry to the internal refresh request, plain default in ns
  localparam int TCKE_NS = 5;
  localparam int TCKE_CYC = (TCKE_NS * CLK_MHZ + 999) / 1000;
  localparam int TXS_NS = 170;
  localparam int TXS_CYC = (TXS_NS * CLK_MHZ + 999) / 1000;
  localparam int TXSDLL_NCK = 512;
  localparam int TCPDED_NCK = 1;
  localparam int TXP_NS = 6;
  localparam int TXP_CYC = (TXP_NS * CLK_MHZ + 999) / 1000;
  localparam int TXPDLL_NS = 24;
  localparam int TXPDLL_CYC = (TXPDLL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;

  // mode bits
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int MR0_PPD_BIT = 12;

endpackage : dsr_pkg

// *** dsr_timer.sv ***
// dsr_timer: loadable down counter with a done flag
// assumes: load and value are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module dsr_timer #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign cnt_d = load ? value :
                 (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  assign done = (cnt_q == '0) && !load;

  always_ff @(posedge clk) begin
    if (rst) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule : dsr_timer
`default_nettype wire

// *** dsr_lowpower_chk.sv ***
// dsr_lowpower_chk: port-level assertions for the low-power control
// assumes: bound to dsr_lowpower, one clock domain, RST synchronous
`timescale 1ns/100ps
`default_nettype none
module dsr_lowpower_chk #(
  parameter int TXSDLL = 512
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic CKE,
  input wire dsr_pkg::dsr_cmd_t CMD,
  input wire logic ANY_BANK_OPEN,
  input wire logic MR0_A12,
  input wire dsr_pkg::dsr_status_t STATUS,
  input wire logic CMD_READY
);
  localparam int RF_MAX = dsr_pkg::TCKE_CYC + 2;
  localparam int TXS_LO = dsr_pkg::TXS_CYC - 4;
  logic nop;
  assign nop = CMD.cs_n || (CMD == 4'h7);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || !RESET_N);
  sequence sr_taken;
    $past(CKE) && !CKE && CMD == 4'h1 && CMD_READY;
  endsequence
  sequence sr_left;
    STATUS.in_self_refresh && !$past(CKE) && CKE && nop;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  sr_entry_a: assert property (sr_taken |=> STATUS.in_self_refresh)
    else $error("self-refresh not entered");
  dll_off_a: assert property (STATUS.in_self_refresh |-> !STATUS.dll_on)
    else $error("dll on in self-refresh");
  sr_refresh_a: assert property ($rose(STATUS.in_self_refresh) |-> ##[0:RF_MAX] STATUS.refresh_req)
    else $error("no internal refresh");
  sr_exit_a: assert property (sr_left |=> !STATUS.in_self_refresh && STATUS.dll_reset)
    else $error("self-refresh exit wrong");
  txs_wait_a: assert property (sr_left |-> ##TXS_LO !CMD_READY ##[1:8] CMD_READY)
    else $error("exit wait wrong");
  pd_entry_a: assert property (CMD_READY && $past(CKE) && !CKE && nop |=> STATUS.in_power_down)
    else $error("power-down not entered");
  pd_kind_a: assert property ($rose(STATUS.in_power_down) |-> STATUS.pd_active == $past(ANY_BANK_OPEN))
    else $error("power-down kind wrong");
  pd_slow_a: assert property ($rose(STATUS.in_power_down) |-> STATUS.pd_slow_exit == (!$past(ANY_BANK_OPEN) && !$past(MR0_A12)))
    else $error("slow exit choice wrong");
  pd_bufs_a: assert property (STATUS.in_power_down && $past(STATUS.in_power_down) |-> !STATUS.cmd_rx_on && !STATUS.io_buf_on)
    else $error("buffers on in power-down");
  pd_exit_a: assert property (STATUS.in_power_down && !$past(CKE) && CKE && nop |=> !STATUS.in_power_down)
    else $error("power-down exit missed");
  reset_pd_a: assert property (disable iff (RST) !RESET_N |=> !STATUS.in_power_down)
    else $error("reset pin ignored");
endmodule : dsr_lowpower_chk
bind dsr_lowpower dsr_lowpower_chk #(.TXSDLL(TXSDLL)) chk (.CLK, .RST,
  .RESET_N, .CKE, .CMD, .ANY_BANK_OPEN, .MR0_A12, .STATUS, .CMD_READY);
`default_nettype wire

// *** dsr_ctrl_model.sv ***
// dsr_ctrl_model: memory controller driving CKE and the command pins
// assumes: op 0 active, 1 self-refresh, 2 power-down; held while wanted
`timescale 1ns/100ps
`default_nettype none
module dsr_ctrl_model (
  input wire logic clk,
  input wire logic [1:0] op,
  output logic cke,
  output var dsr_pkg::dsr_cmd_t cmd
);
  // odt never raised; no read, write, mode or refresh command is driven
  initial begin
    cke = 1'h1;
    cmd = 4'hF;
  end
  // entry only from idle; deselect everywhere else, exit included
  always @(posedge clk) begin
    cke <= (op == 2'h0);
    cmd <= (op == 2'h1 && cke) ? 4'h1 : 4'hF;
  end
endmodule : dsr_ctrl_model
`default_nettype wire

// *** dram_self_refresh_power_down_test.sv ***
// dram_self_refresh_power_down_test: self-checking bench for dsr_lowpower
// assumes: controller model drives CKE/CMD, bench drives the rest
`timescale 1ns/100ps
`default_nettype none
module dram_self_refresh_power_down_test;
  logic clk, rst, reset_n, cke, bank_open, mr1_a0, mr0_a12;
  logic cmd_ready, dll_ready;
  logic [1:0] op;
  dsr_pkg::dsr_cmd_t cmd;
  dsr_pkg::dsr_status_t status;
  int err_count = 0;
  int tests_run = 0;
  // short relock keeps the run brief
  dsr_lowpower #(.TXSDLL(8)) DUT (.CLK(clk), .RST(rst), .RESET_N(reset_n),
    .CKE(cke), .CMD(cmd), .ANY_BANK_OPEN(bank_open), .MR1_A0(mr1_a0),
    .MR0_A12(mr0_a12), .STATUS(status), .CMD_READY(cmd_ready),
    .DLL_READY(dll_ready));
  dsr_ctrl_model model (.clk(clk), .op(op), .cke(cke), .cmd(cmd));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] seen,
    input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // model adds one edge, design and status one more
  // status follows the next state, so one-cycle pulses are still up here
  task automatic go(input logic [1:0] o);
    @(posedge clk);
    op <= o;
    repeat (2) @(posedge clk);
    #1;
  endtask : go
  task automatic wait_ready(output int n);
    n = 0;
    while (cmd_ready !== 1'h1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_ready
  task automatic sr_test;
    int n;
    go(2'h1);
    check("sr entry", {status.in_self_refresh, status.dll_on, cmd_ready}, 3'h4);
    n = 0;
    repeat (dsr_pkg::TCKE_CYC + 3) begin
      if (status.refresh_req === 1'h1) n++;
      @(posedge clk);
      #1;
    end
    check("sr refresh", n > 0, 1'h1);
    go(2'h0);
    check("sr exit", {status.in_self_refresh, status.dll_reset, status.dll_on, cmd_ready}, 4'h6);
    wait_ready(n);
    check("txs wait", n >= dsr_pkg::TXS_CYC - 4 && n <= dsr_pkg::TXS_CYC + 2, 1'h1);
    repeat (12) @(posedge clk);
    #1;
    check("dll relock", dll_ready, 1'h1);
  endtask : sr_test
  task automatic pd_test(input logic bank, input logic a12);
    logic slow;
    int n;
    slow = !bank && !a12;
    @(posedge clk);
    bank_open <= bank;
    mr0_a12 <= a12;
    go(2'h2);
    check("pd entry", {status.in_power_down, status.pd_active,
      status.pd_slow_exit, status.dll_on, status.io_buf_on,
      status.cmd_rx_on}, {1'h1, bank, slow, !slow, 2'h1});
    @(posedge clk);
    #1;
    check("pd rx off", status.cmd_rx_on, 1'h0);
    go(2'h0);
    check("pd exit", status.in_power_down, 1'h0);
    wait_ready(n);
    check("txp wait", n >= dsr_pkg::TXP_CYC, 1'h1);
    check("txp late", n <= dsr_pkg::TXP_CYC + 2, 1'h1);
    check("pd dll early", dll_ready, !slow);
    repeat (dsr_pkg::TXPDLL_CYC + 3) @(posedge clk);
    #1;
    check("pd dll", dll_ready, 1'h1);
  endtask : pd_test
  task automatic reset_test;
    int n;
    go(2'h2);
    check("reset pd before", status.in_power_down, 1'h1);
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check("reset pd", status.in_power_down, 1'h0);
    @(posedge clk);
    reset_n <= 1'h1;
    go(2'h0);
    wait_ready(n);
    check("after reset", cmd_ready, 1'h1);
  endtask : reset_test
  // dll disabled by mode bit, then enabled again
  task automatic dll_mode_test;
    @(posedge clk);
    mr1_a0 <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    check("dll disabled", {status.dll_on, dll_ready}, 2'h0);
    @(posedge clk);
    mr1_a0 <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check("dll enabled", {status.dll_on, dll_ready}, 2'h3);
  endtask : dll_mode_test
  initial begin
    reset_n = 1'h1;
    bank_open = 1'h0;
    mr1_a0 = 1'h0;
    mr0_a12 = 1'h0;
    op = 2'h0;
    rst = 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    check("dll ready", dll_ready, 1'h1);
    sr_test;
    pd_test(1'h1, 1'h0);
    pd_test(1'h0, 1'h0);
    pd_test(1'h0, 1'h1);
    reset_test;
    dll_mode_test;
    results;
  end
  // whole run is well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    results;
  end
endmodule : dram_self_refresh_power_down_test
`default_nettype wire
